// ===== logic/atf_task_file.sv
// task-file command decoder, host control and status with an AXI4-Lite register slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "atf_defines.svh"

module atf_task_file (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// media engine dispatch
	output logic op_start,
	output atf_pkg::atf_op_req_t op_req,
	input wire logic op_done,
	input wire logic op_error,
	// card interrupt request
	output logic card_irq_request_n
);
	atf_pkg::atf_state_t state_reg;
	atf_pkg::atf_power_t power_reg;
	atf_pkg::atf_op_req_t op_req_reg;
	atf_pkg::atf_decode_t dec;
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg, op_start_reg, irq_n_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg, wdata_reg;
	logic [7:0] awaddr_reg;
	logic [3:0] wstrb_reg;
	logic [7:0] feature_reg, seccnt_reg, secnum_reg, drvhead_reg, config_reg;
	logic [15:0] cyl_reg;
	logic irq_disable_reg, err_reg, drq_reg, irq_pend_reg;
	logic wr_fire, rd_fire, hc_write, cmd_write, range_ok, cmd_ok, backend_kind, tf_write_ok, status_read;
	logic [7:0] echo_val;
	logic [8:0] count_val;

	// command table; the X-nibble codes match on the high nibble only
	function automatic atf_pkg::atf_decode_t decode(input logic [7:0] code);
		atf_pkg::atf_decode_t d;
		d = '{valid: 1'b1, kind: atf_pkg::ATF_K_NOP, uses_sn: 1'b0, uses_hd: 1'b0};
		case (code)
			`ATF_CMD_RD_A, `ATF_CMD_RD_B, `ATF_CMD_RDL_A, `ATF_CMD_RDL_B, `ATF_CMD_RDV_A, `ATF_CMD_RDV_B,
			`ATF_CMD_RDM: begin
				d.kind = atf_pkg::ATF_K_READ;
				d.uses_sn = 1'b1;
				d.uses_hd = 1'b1;
			end
			`ATF_CMD_WR_A, `ATF_CMD_WR_B, `ATF_CMD_WRL_A, `ATF_CMD_WRL_B, `ATF_CMD_WRNE, `ATF_CMD_WRV,
			`ATF_CMD_WRM, `ATF_CMD_WRMNE: begin
				d.kind = atf_pkg::ATF_K_WRITE;
				d.uses_sn = 1'b1;
				d.uses_hd = 1'b1;
			end
			`ATF_CMD_ERASE: begin
				d.kind = atf_pkg::ATF_K_ERASE;
				d.uses_sn = 1'b1;
				d.uses_hd = 1'b1;
			end
			`ATF_CMD_FORMAT: begin
				d.kind = atf_pkg::ATF_K_FORMAT;
				d.uses_hd = 1'b1;
			end
			`ATF_CMD_XLATE: begin
				d.uses_sn = 1'b1;
				d.uses_hd = 1'b1;
			end
			`ATF_CMD_IDENT: d.kind = atf_pkg::ATF_K_IDENT;
			`ATF_CMD_DIAG: d.kind = atf_pkg::ATF_K_DIAG;
			`ATF_CMD_PCHK_A, `ATF_CMD_PCHK_B: d.kind = atf_pkg::ATF_K_PCHECK;
			`ATF_CMD_IDLE_A, `ATF_CMD_IDLE_B, `ATF_CMD_IDLEI_A, `ATF_CMD_IDLEI_B: d.kind = atf_pkg::ATF_K_PIDLE;
			`ATF_CMD_STBY_A, `ATF_CMD_STBY_B, `ATF_CMD_STBYI_A, `ATF_CMD_STBYI_B: d.kind = atf_pkg::ATF_K_PSTBY;
			`ATF_CMD_SLEEP_A, `ATF_CMD_SLEEP_B: d.kind = atf_pkg::ATF_K_PSLEEP;
			`ATF_CMD_INITP, `ATF_CMD_WEAR: d.uses_hd = 1'b1;
			`ATF_CMD_FEAT, `ATF_CMD_RDBUF, `ATF_CMD_WRBUF, `ATF_CMD_SENSE, `ATF_CMD_SETMUL: d.kind = atf_pkg::ATF_K_NOP;
			default: begin
				if (code[7:4] == `ATF_CMD_SEEK_HI) begin
					d.uses_sn = 1'b1;
					d.uses_hd = 1'b1;
				end else if (code[7:4] != `ATF_CMD_RECAL_HI) begin
					d.valid = 1'b0;
					d.kind = atf_pkg::ATF_K_NONE;
				end
			end
		endcase
		return d;
	endfunction

	// bus events and command checks
	assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
	assign rd_fire = s_axi_arvalid && arready_reg;
	assign hc_write = wr_fire && awaddr_reg == `ATF_OFF_HOSTCTL && wstrb_reg[0];
	assign cmd_write = wr_fire && awaddr_reg == `ATF_OFF_COMMAND && wstrb_reg[0] && state_reg == atf_pkg::ATF_ST_READY;
	assign dec = decode(wdata_reg[7:0]);
	assign range_ok = !(dec.uses_sn && (secnum_reg < `ATF_SN_MIN || secnum_reg > `ATF_SN_MAX))
		&& !(dec.uses_hd && drvhead_reg[3:0] > `ATF_HD_MAX);
	assign cmd_ok = dec.valid && range_ok;
	assign backend_kind = dec.kind inside {atf_pkg::ATF_K_READ, atf_pkg::ATF_K_WRITE, atf_pkg::ATF_K_ERASE,
		atf_pkg::ATF_K_FORMAT, atf_pkg::ATF_K_IDENT, atf_pkg::ATF_K_DIAG};
	// task-file writes only land while ready, so a busy card keeps its parameters
	assign tf_write_ok = wr_fire && state_reg == atf_pkg::ATF_ST_READY;
	assign status_read = rd_fire && s_axi_araddr == `ATF_OFF_STATUS;
	// zero count stands for a full 256-sector run on data transfers
	assign count_val = (seccnt_reg == `ATF_RST_BYTE && dec.kind inside {atf_pkg::ATF_K_READ, atf_pkg::ATF_K_WRITE})
		? `ATF_SC_FULL : {1'b0, seccnt_reg};
	// undefined echo bits read as zero
	assign echo_val = {2'b00, ~drvhead_reg[3:0], 2'b00};

	// write address and data channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			awaddr_reg <= `ATF_RST_BYTE;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				awready_reg <= 1'b0;
				awaddr_reg <= s_axi_awaddr;
			end else if (bvalid_reg && s_axi_bready) begin
				awready_reg <= 1'b1;
			end
			if (s_axi_wvalid && wready_reg) begin
				wready_reg <= 1'b0;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (bvalid_reg && s_axi_bready) begin
				wready_reg <= 1'b1;
			end
		end
	end

	// write response; read-only and unmapped offsets answer decode error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `ATF_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			case (awaddr_reg)
				`ATF_OFF_FEATURE, `ATF_OFF_SECCNT, `ATF_OFF_SECNUM, `ATF_OFF_CYL, `ATF_OFF_DRVHEAD,
				`ATF_OFF_COMMAND, `ATF_OFF_HOSTCTL, `ATF_OFF_CONFIG: bresp_reg <= `ATF_RESP_OKAY;
				default: bresp_reg <= `ATF_RESP_DECERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// read channel; status shows only busy while busy or in reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `ATF_RESP_OKAY;
		end else if (rd_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= `ATF_RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			case (s_axi_araddr)
				`ATF_OFF_FEATURE: rdata_reg[7:0] <= feature_reg;
				`ATF_OFF_SECCNT: rdata_reg[7:0] <= seccnt_reg;
				`ATF_OFF_SECNUM: rdata_reg[7:0] <= secnum_reg;
				`ATF_OFF_CYL: rdata_reg[15:0] <= cyl_reg;
				`ATF_OFF_DRVHEAD: rdata_reg[7:0] <= drvhead_reg;
				`ATF_OFF_ECHO: rdata_reg[7:0] <= echo_val;
				`ATF_OFF_CONFIG: rdata_reg[7:0] <= config_reg;
				`ATF_OFF_POWER: rdata_reg[1:0] <= power_reg;
				`ATF_OFF_COMMAND, `ATF_OFF_HOSTCTL: rdata_reg <= 32'h0000_0000;
				`ATF_OFF_STATUS: begin
					if (state_reg != atf_pkg::ATF_ST_READY) begin
						rdata_reg[`ATF_ST_BSY] <= 1'b1;
					end else begin
						rdata_reg[`ATF_ST_DRDY] <= 1'b1;
						rdata_reg[`ATF_ST_DSC] <= 1'b1;
						rdata_reg[`ATF_ST_DRQ] <= drq_reg;
						rdata_reg[`ATF_ST_ERR] <= err_reg;
					end
				end
				default: rresp_reg <= `ATF_RESP_DECERR;
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// host control: only soft reset and irq disable are kept, the rest is ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_disable_reg <= 1'b0;
		end else if (hc_write) begin
			irq_disable_reg <= wdata_reg[`ATF_HC_IRQ_DISABLE_BIT];
		end
	end

	// control state: soft reset from any state, held until the bit is written back to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= atf_pkg::ATF_ST_READY;
		end else begin
			case (state_reg)
				atf_pkg::ATF_ST_READY: begin
					if (hc_write && wdata_reg[`ATF_HC_SOFT_RESET_BIT]) begin
						state_reg <= atf_pkg::ATF_ST_RESET;
					end else if (cmd_write && cmd_ok && backend_kind) begin
						state_reg <= atf_pkg::ATF_ST_BUSY;
					end
				end
				atf_pkg::ATF_ST_BUSY: begin
					if (hc_write && wdata_reg[`ATF_HC_SOFT_RESET_BIT]) begin
						state_reg <= atf_pkg::ATF_ST_RESET;
					end else if (op_done) begin
						state_reg <= atf_pkg::ATF_ST_READY;
					end
				end
				atf_pkg::ATF_ST_RESET: begin
					if (hc_write && !wdata_reg[`ATF_HC_SOFT_RESET_BIT]) begin
						state_reg <= atf_pkg::ATF_ST_READY;
					end
				end
				default: state_reg <= atf_pkg::ATF_ST_READY;
			endcase
		end
	end

	// task-file parameters; soft reset restores them, configuration is left alone
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg == atf_pkg::ATF_ST_RESET) begin
			feature_reg <= `ATF_RST_BYTE;
			seccnt_reg <= `ATF_RST_BYTE;
			secnum_reg <= `ATF_RST_SECNUM;
			cyl_reg <= `ATF_RST_CYL;
			drvhead_reg <= `ATF_RST_BYTE;
		end else if (cmd_write && cmd_ok && dec.kind == atf_pkg::ATF_K_PCHECK) begin
			// awake modes report FFH, standby and sleep report 00H
			seccnt_reg <= power_reg inside {atf_pkg::ATF_PWR_STANDBY, atf_pkg::ATF_PWR_SLEEP}
				? `ATF_PWR_ASLEEP_SC : `ATF_PWR_AWAKE_SC;
		end else if (tf_write_ok) begin
			if (awaddr_reg == `ATF_OFF_FEATURE && wstrb_reg[0]) feature_reg <= wdata_reg[7:0];
			if (awaddr_reg == `ATF_OFF_SECCNT && wstrb_reg[0]) seccnt_reg <= wdata_reg[7:0];
			if (awaddr_reg == `ATF_OFF_SECNUM && wstrb_reg[0]) secnum_reg <= wdata_reg[7:0];
			if (awaddr_reg == `ATF_OFF_CYL && wstrb_reg[0]) cyl_reg[7:0] <= wdata_reg[7:0];
			if (awaddr_reg == `ATF_OFF_CYL && wstrb_reg[1]) cyl_reg[15:8] <= wdata_reg[15:8];
			if (awaddr_reg == `ATF_OFF_DRVHEAD && wstrb_reg[0]) drvhead_reg <= wdata_reg[7:0];
		end
	end

	// configuration is cleared only by the hardware reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			config_reg <= `ATF_RST_BYTE;
		end else if (wr_fire && awaddr_reg == `ATF_OFF_CONFIG && wstrb_reg[0]) begin
			config_reg <= wdata_reg[7:0];
		end
	end

	// power mode follows the power commands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_reg <= atf_pkg::ATF_PWR_ACTIVE;
		end else if (cmd_write && cmd_ok) begin
			case (dec.kind)
				atf_pkg::ATF_K_PIDLE: power_reg <= atf_pkg::ATF_PWR_IDLE;
				atf_pkg::ATF_K_PSTBY: power_reg <= atf_pkg::ATF_PWR_STANDBY;
				atf_pkg::ATF_K_PSLEEP: power_reg <= atf_pkg::ATF_PWR_SLEEP;
				atf_pkg::ATF_K_PCHECK, atf_pkg::ATF_K_NOP: power_reg <= power_reg;
				default: power_reg <= atf_pkg::ATF_PWR_ACTIVE;
			endcase
		end
	end

	// error and data-request flags; a new command clears them, a failure sets error
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg == atf_pkg::ATF_ST_RESET) begin
			err_reg <= 1'b0;
			drq_reg <= 1'b0;
		end else if (cmd_write) begin
			err_reg <= !cmd_ok;
			drq_reg <= 1'b0;
		end else if (state_reg == atf_pkg::ATF_ST_BUSY && op_done) begin
			err_reg <= op_error;
			// read, identify and format-track data move through the data port
			drq_reg <= !op_error && op_req_reg.kind inside {atf_pkg::ATF_K_READ, atf_pkg::ATF_K_IDENT,
				atf_pkg::ATF_K_FORMAT};
		end
	end

	// dispatch to the media engine, one pulse per accepted command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_start_reg <= 1'b0;
			op_req_reg <= '0;
		end else begin
			op_start_reg <= cmd_write && cmd_ok && backend_kind;
			if (cmd_write && cmd_ok && backend_kind) begin
				op_req_reg.kind <= dec.kind;
				op_req_reg.drive <= drvhead_reg[`ATF_DH_DRV];
				op_req_reg.head <= drvhead_reg[3:0];
				op_req_reg.cylinder <= cyl_reg;
				op_req_reg.sector <= secnum_reg;
				op_req_reg.count <= count_val;
			end
		end
	end

	// pending interrupt: completion sets, status read or new command clears, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg == atf_pkg::ATF_ST_RESET) begin
			irq_pend_reg <= 1'b0;
		end else if ((cmd_write && !(cmd_ok && backend_kind)) || (state_reg == atf_pkg::ATF_ST_BUSY && op_done)) begin
			irq_pend_reg <= 1'b1;
		end else if (status_read || cmd_write) begin
			irq_pend_reg <= 1'b0;
		end
	end

	// registered irq pin, so it lags the pending flag by one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= !(irq_pend_reg && !irq_disable_reg);
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign op_start = op_start_reg;
	assign op_req = op_req_reg;
	assign card_irq_request_n = irq_n_reg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_accept;
		cmd_write && cmd_ok && backend_kind;
	endsequence
	sequence s_enter_reset;
		hc_write && wdata_reg[`ATF_HC_SOFT_RESET_BIT] && state_reg != atf_pkg::ATF_ST_RESET;
	endsequence

	property p_soft_reset_bit_enter;
		s_enter_reset |=> state_reg == atf_pkg::ATF_ST_RESET ##1 !err_reg && !irq_pend_reg;
	endproperty
	a_soft_reset_bit_enter: assert property (p_soft_reset_bit_enter) else $error("soft reset not taken");
	property p_cfg_keep;
		s_enter_reset ##1 state_reg == atf_pkg::ATF_ST_RESET |-> $stable(config_reg);
	endproperty
	a_cfg_keep: assert property (p_cfg_keep) else $error("config changed by soft reset");
	property p_reset_hold;
		state_reg == atf_pkg::ATF_ST_RESET && !(hc_write && !wdata_reg[`ATF_HC_SOFT_RESET_BIT])
			|=> state_reg == atf_pkg::ATF_ST_RESET && !op_start_reg;
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("left reset early");
	property p_irq_mask;
		irq_disable_reg |=> card_irq_request_n;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq not suppressed");
	property p_irq_raise;
		irq_pend_reg && !irq_disable_reg |=> !card_irq_request_n;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");
	property p_echo;
		rd_fire && s_axi_araddr == `ATF_OFF_ECHO |=> s_axi_rdata[5:2] == ~$past(drvhead_reg[3:0]);
	endproperty
	a_echo: assert property (p_echo) else $error("echo head bits wrong");
	property p_dispatch;
		s_accept |=> op_start && state_reg == atf_pkg::ATF_ST_BUSY ##1 !op_start;
	endproperty
	a_dispatch: assert property (p_dispatch) else $error("accepted command not dispatched");
	property p_range;
		cmd_write && dec.uses_sn && secnum_reg > `ATF_SN_MAX |=> err_reg && !op_start;
	endproperty
	a_range: assert property (p_range) else $error("sector number range not checked");
	property p_busy;
		state_reg == atf_pkg::ATF_ST_BUSY && !op_done && !hc_write |=> state_reg == atf_pkg::ATF_ST_BUSY;
	endproperty
	a_busy: assert property (p_busy) else $error("busy dropped early");
	property p_err_clear;
		s_accept |=> !err_reg;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error not cleared by command");
	property p_full_count;
		s_accept and (seccnt_reg == `ATF_RST_BYTE && dec.kind == atf_pkg::ATF_K_READ) |=> op_req.count == `ATF_SC_FULL;
	endproperty
	a_full_count: assert property (p_full_count) else $error("zero count not 256");
	property p_reject;
		cmd_write && !dec.valid |=> err_reg && state_reg == atf_pkg::ATF_ST_READY && !op_start;
	endproperty
	a_reject: assert property (p_reject) else $error("bad command not rejected");
endmodule

// ===== inc/atf_defines.svh
// register map, field positions, limits and command codes of the task-file control block
`ifndef ATF_DEFINES_SVH
`define ATF_DEFINES_SVH

`define ATF_OFF_FEATURE 8'h00
`define ATF_OFF_SECCNT 8'h04
`define ATF_OFF_SECNUM 8'h08
`define ATF_OFF_CYL 8'h0C
`define ATF_OFF_DRVHEAD 8'h10
`define ATF_OFF_COMMAND 8'h14
`define ATF_OFF_STATUS 8'h18
`define ATF_OFF_HOSTCTL 8'h1C
`define ATF_OFF_ECHO 8'h20
`define ATF_OFF_CONFIG 8'h24
`define ATF_OFF_POWER 8'h28

`define ATF_HC_SOFT_RESET_BIT 2
`define ATF_HC_IRQ_DISABLE_BIT 1
`define ATF_ST_BSY 7
`define ATF_ST_DRDY 6
`define ATF_ST_DSC 4
`define ATF_ST_DRQ 3
`define ATF_ST_ERR 0
`define ATF_DH_DRV 4

`define ATF_RST_BYTE 8'h00
`define ATF_RST_CYL 16'h0000
`define ATF_RST_SECNUM 8'h01
`define ATF_SN_MIN 8'h01
`define ATF_SN_MAX 8'h20
`define ATF_HD_MAX 4'h3
`define ATF_SC_FULL 9'h100
`define ATF_PWR_AWAKE_SC 8'hFF
`define ATF_PWR_ASLEEP_SC 8'h00
`define ATF_RESP_OKAY 2'b00
`define ATF_RESP_DECERR 2'b11

`define ATF_CMD_RD_A 8'h20
`define ATF_CMD_RD_B 8'h21
`define ATF_CMD_RDL_A 8'h22
`define ATF_CMD_RDL_B 8'h23
`define ATF_CMD_RDV_A 8'h40
`define ATF_CMD_RDV_B 8'h41
`define ATF_CMD_RDM 8'hC4
`define ATF_CMD_WR_A 8'h30
`define ATF_CMD_WR_B 8'h31
`define ATF_CMD_WRL_A 8'h32
`define ATF_CMD_WRL_B 8'h33
`define ATF_CMD_WRNE 8'h38
`define ATF_CMD_WRV 8'h3C
`define ATF_CMD_WRM 8'hC5
`define ATF_CMD_WRMNE 8'hCD
`define ATF_CMD_ERASE 8'hC0
`define ATF_CMD_FORMAT 8'h50
`define ATF_CMD_IDENT 8'hEC
`define ATF_CMD_DIAG 8'h90
`define ATF_CMD_PCHK_A 8'hE5
`define ATF_CMD_PCHK_B 8'h98
`define ATF_CMD_IDLE_A 8'hE3
`define ATF_CMD_IDLE_B 8'h97
`define ATF_CMD_IDLEI_A 8'hE1
`define ATF_CMD_IDLEI_B 8'h95
`define ATF_CMD_STBY_A 8'hE2
`define ATF_CMD_STBY_B 8'h96
`define ATF_CMD_STBYI_A 8'hE0
`define ATF_CMD_STBYI_B 8'h94
`define ATF_CMD_SLEEP_A 8'hE6
`define ATF_CMD_SLEEP_B 8'h99
`define ATF_CMD_FEAT 8'hEF
`define ATF_CMD_INITP 8'h91
`define ATF_CMD_RDBUF 8'hE4
`define ATF_CMD_WRBUF 8'hE8
`define ATF_CMD_SENSE 8'h03
`define ATF_CMD_SETMUL 8'hC6
`define ATF_CMD_XLATE 8'h87
`define ATF_CMD_WEAR 8'hF5
`define ATF_CMD_RECAL_HI 4'h1
`define ATF_CMD_SEEK_HI 4'h7

`endif

// ===== inc/atf_pkg.sv
// types shared by the task-file control block
package atf_pkg;
	typedef enum logic [1:0] {
		ATF_ST_READY = 2'b00,
		ATF_ST_BUSY = 2'b01,
		ATF_ST_RESET = 2'b10
	} atf_state_t;

	typedef enum logic [3:0] {
		ATF_K_NONE = 4'h0,
		ATF_K_READ = 4'h1,
		ATF_K_WRITE = 4'h2,
		ATF_K_ERASE = 4'h3,
		ATF_K_FORMAT = 4'h4,
		ATF_K_IDENT = 4'h5,
		ATF_K_DIAG = 4'h6,
		ATF_K_PCHECK = 4'h7,
		ATF_K_PIDLE = 4'h8,
		ATF_K_PSTBY = 4'h9,
		ATF_K_PSLEEP = 4'hA,
		ATF_K_NOP = 4'hB
	} atf_kind_t;

	typedef enum logic [1:0] {
		ATF_PWR_ACTIVE = 2'b00,
		ATF_PWR_IDLE = 2'b01,
		ATF_PWR_STANDBY = 2'b10,
		ATF_PWR_SLEEP = 2'b11
	} atf_power_t;

	typedef struct packed {
		logic valid;
		atf_kind_t kind;
		logic uses_sn;
		logic uses_hd;
	} atf_decode_t;

	typedef struct packed {
		atf_kind_t kind;
		logic drive;
		logic [3:0] head;
		logic [15:0] cylinder;
		logic [7:0] sector;
		logic [8:0] count;
	} atf_op_req_t;
endpackage

// ===== verif/atf_media_model.sv
// media engine stand-in that answers each dispatched operation after a delay
`timescale 1ns/1ns
module atf_media_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// dispatch handshake
	input wire logic op_start,
	output logic op_done,
	output logic op_error,
	// scenario controls
	input wire logic slow,
	input wire logic fail
);
	int cnt;
	// countdown from dispatch; error line shows junk outside the done pulse
	always_ff @(posedge aclk) begin
		op_done <= 1'h0;
		op_error <= ~fail;
		if (!aresetn)
			cnt <= 0;
		else if (op_start)
			cnt <= slow ? 40 : 12;
		else if (cnt == 1) begin
			op_done <= 1'h1;
			op_error <= fail;
			cnt <= 0;
		end else if (cnt > 1)
			cnt <= cnt - 1;
	end
endmodule

// ===== verif/ata_task_file_command_control_tb.sv
// self-checking bench for the task-file control block
`timescale 1ns/1ns
`include "atf_defines.svh"
module ata_task_file_command_control_tb;
	localparam logic [7:0] CD [9] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'hC4, 8'hC0, 8'h50, 8'hEC, 8'h90};
	localparam logic [3:0] KD [9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6};
	localparam logic [7:0] BS [4] = '{8'h21, 8'h00, 8'h01, 8'h01};
	localparam logic [7:0] BH [4] = '{8'h00, 8'h00, 8'h04, 8'h00};
	localparam logic [7:0] BC [4] = '{8'h20, 8'h30, 8'hC0, 8'hFF};
	localparam logic [7:0] PW [2] = '{8'hE5, 8'h98};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_start, op_done, op_error;
	logic card_irq_request_n, slow = 1'h0, fail = 1'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	atf_pkg::atf_op_req_t op_req, eo;
	logic [33:0] xq[$];
	// dispatch notes are as wide as the whole request word
	logic [41:0] oq[$], mq[$];
	int failures = 0, checks_done = 0, cyc = 0;

	always #5 aclk = ~aclk;

	atf_task_file dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_start, .op_req, .op_done,
		.op_error, .card_irq_request_n);
	atf_media_model media (.aclk, .aresetn, .op_start, .op_done, .op_error, .slow, .fail);

	task automatic chk(input string nm, input logic [41:0] s, input logic [41:0] e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic test_done();
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		chk("bresp", 42'(s_axi_bresp), 42'(er));
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask

	// the expected word is noted first; the watcher compares it
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		xq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask

	task automatic ld(input logic [7:0] sc, input logic [7:0] sn, input logic [15:0] cy, input logic [7:0] dh);
		wr(`ATF_OFF_SECCNT, {24'h0, sc});
		wr(`ATF_OFF_SECNUM, {24'h0, sn});
		wr(`ATF_OFF_CYL, {16'h0, cy});
		wr(`ATF_OFF_DRVHEAD, {24'h0, dh});
	endtask

	// watcher: oldest note against each result; also cuts a hang short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (s_axi_rvalid && s_axi_rready)
			chk("read", 42'({s_axi_rresp, s_axi_rdata}), 42'(xq.pop_front()));
		if (op_start && oq.size() == 0)
			chk("op_start", 42'h1, 42'h0);
		else if (op_start)
			chk("op_req", op_req & mq.pop_front(), oq.pop_front());
		if (cyc == 20000) begin
			failures++;
			test_done();
		end
	end

	initial begin
		logic [7:0] sc, sn;
		logic [3:0] hd;
		logic [15:0] cy;
		logic [41:0] m;
		logic dv;
		void'($urandom(47753));
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(`ATF_OFF_STATUS, 34'h50);
		wr(`ATF_OFF_ECHO, 32'h0, `ATF_RESP_DECERR);
		wr(8'h40, 32'h0, `ATF_RESP_DECERR);
		// every dispatching kind; zero counts and sector bounds first
		for (int i = 0; i < 9; i++) begin
			sc = (i < 4) ? 8'h00 : 8'($urandom);
			sn = (i == 0) ? 8'h01 : (i == 1) ? 8'h20 : 8'($urandom_range(32, 1));
			hd = 4'($urandom_range(3, 0));
			dv = 1'($urandom);
			cy = 16'($urandom);
			ld(sc, sn, cy, {3'h0, dv, hd});
			rd(`ATF_OFF_ECHO, {28'h0, ~hd, 2'h0});
			eo = '{kind: atf_pkg::atf_kind_t'(KD[i]), drive: dv, head: hd, cylinder: cy, sector: sn,
				count: (KD[i] < 4'h3 && sc == 8'h00) ? 9'h100 : {1'h0, sc}};
			// format ignores the sector number; identify and diagnostic carry only their kind
			m = (i < 6) ? '1 : (i == 6) ? ~42'h1FE00 : {4'hF, 38'h0};
			oq.push_back(eo & m);
			mq.push_back(m);
			slow <= i[0];
			fail <= (i == 5);
			wr(`ATF_OFF_COMMAND, {24'h0, CD[i]});
			rd(`ATF_OFF_STATUS, 34'h80);
			while (!op_done)
				@(posedge aclk);
			repeat (2) @(posedge aclk);
			chk("irq_n", 42'(card_irq_request_n), 42'h0);
			rd(`ATF_OFF_STATUS, (i == 5) ? 34'h51 : (KD[i] == 1 || KD[i] == 4 || KD[i] == 5) ? 34'h58 : 34'h50);
			chk("irq_n", 42'(card_irq_request_n), 42'h1);
		end
		// out-of-range sector or head and an unknown code are refused
		for (int i = 0; i < 4; i++) begin
			ld(8'h01, BS[i], 16'h0, BH[i]);
			wr(`ATF_OFF_COMMAND, {24'h0, BC[i]});
			rd(`ATF_OFF_STATUS, 34'h51);
		end
		// both power check codes with the request line masked
		wr(`ATF_OFF_HOSTCTL, 32'h0A);
		foreach (PW[i]) begin
			wr(`ATF_OFF_SECCNT, 32'h0);
			wr(`ATF_OFF_COMMAND, {24'h0, PW[i]});
			rd(`ATF_OFF_SECCNT, 34'hFF);
		end
		// standby makes the power check answer asleep
		wr(`ATF_OFF_COMMAND, 32'hE2);
		rd(`ATF_OFF_POWER, 34'h2);
		wr(`ATF_OFF_COMMAND, 32'hE5);
		rd(`ATF_OFF_SECCNT, 34'h00);
		// unmapped offset answers decode error on read too
		rd(8'h40, 34'h3_0000_0000);
		chk("irq_n", 42'(card_irq_request_n), 42'h1);
		wr(`ATF_OFF_HOSTCTL, 32'hF8);
		chk("irq_n", 42'(card_irq_request_n), 42'h0);
		rd(`ATF_OFF_STATUS, 34'h50);
		// soft reset holds busy, swallows commands, spares configuration
		wr(`ATF_OFF_CONFIG, 32'h5A);
		wr(`ATF_OFF_SECNUM, 32'h07);
		wr(`ATF_OFF_DRVHEAD, 32'h03);
		wr(`ATF_OFF_HOSTCTL, 32'h0C);
		rd(`ATF_OFF_STATUS, 34'h80);
		wr(`ATF_OFF_COMMAND, 32'h20);
		repeat (30) @(posedge aclk);
		rd(`ATF_OFF_STATUS, 34'h80);
		wr(`ATF_OFF_HOSTCTL, 32'h08);
		rd(`ATF_OFF_STATUS, 34'h50);
		rd(`ATF_OFF_SECNUM, 34'h01);
		rd(`ATF_OFF_ECHO, 34'h3C);
		rd(`ATF_OFF_CONFIG, 34'h5A);
		repeat (50) @(posedge aclk);
		test_done();
	end
endmodule
